//--- common/arrb_pkg.sv
// package for the acyclic read response builder
package arrb_pkg;
	// ----------------------------------------
	// record layout (word indices)
	// ----------------------------------------
	localparam logic [6:0]  OFS_CODE       = 7'h00;
	localparam logic [6:0]  OFS_STATION    = 7'h01;
	localparam logic [6:0]  OFS_LEN_DET1   = 7'h02;
	localparam logic [6:0]  OFS_SLOT_DET2  = 7'h03;
	localparam logic [6:0]  OFS_INDEX_DET3 = 7'h04;
	localparam logic [6:0]  OFS_DATA_FIRST = 7'h05;
	localparam logic [6:0]  OFS_DATA_LAST  = 7'h7C;
	localparam logic [6:0]  OFS_TAIL_FIRST = 7'h7D;
	localparam logic [6:0]  OFS_LAST       = 7'h7F;
	localparam int          REC_WORDS      = 128;
	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [15:0] RESP_CLASS1    = 16'hA400;
	localparam logic [15:0] RESP_CLASS2    = 16'hA410;
	localparam logic [15:0] ERR_SLAVE      = 16'hE403;
	localparam logic [15:0] NO_DETAIL      = 16'hFFFF;
	localparam logic [15:0] ZERO_WORD      = 16'h0000;
	localparam logic [7:0]  MAX_LEN        = 8'hF0;
	// ----------------------------------------
	// control/status registers (byte-free word offsets on the host port)
	// ----------------------------------------
	localparam logic [7:0]  REG_REC_BASE   = 8'h00;
	localparam logic [7:0]  REG_STATUS     = 8'h80;
	localparam logic [7:0]  REG_IRQ_STAT   = 8'h81;
	localparam logic [7:0]  REG_IRQ_MASK   = 8'h82;
	localparam logic [1:0]  IRQ_RESET      = 2'h0;
	localparam logic [1:0]  MASK_RESET     = 2'h0;
	localparam int          IRQ_DONE_BIT   = 0;
	localparam int          IRQ_FAIL_BIT   = 1;
	typedef enum logic [1:0] {
		ARRB_IDLE,
		ARRB_BUILD
	} arrb_state_e;
endpackage

//--- hw/arrb_builder.sv
// response record builder with host register port
`timescale 1ns/1ps
// Functional notes
// - on success word 0 holds A400H for a first-class read and A410H for a second-class read.
// - word 1 low byte holds the slave station address in success and failure records.
// - word 1 high byte holds the communication reference for second-class reads, zero otherwise.
// - on success word 2 holds the requested byte count req_len as given, 0 to 255, not clamped to 240.
// - on success word 3 holds the slot number read.
// - on success word 4 holds the index read.
// - bytes beyond the requested length are discarded.
// - every data byte position in words read_data_words without read data is zero.
// - on failure word 0 holds the error code instead of the success code.
// - on failure word 2 holds detail code 1 when word 0 is E403H, else FFFFH.
// - on failure word 3 holds detail code 2 when word 0 is E403H, else FFFFH.
// - on failure word 4 holds detail code 3 when word 0 is E403H, else all ones.
module arrb_builder (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        start,
	input  wire logic        second_class_service,
	input  wire logic        ok,
	input  wire logic [6:0]  slave_station_address,
	input  wire logic [6:0]  communication_reference_number,
	input  wire logic [7:0]  req_len,
	input  wire logic [7:0]  req_slot,
	input  wire logic [7:0]  req_index,
	input  wire logic [15:0] err_code,
	input  wire logic [15:0] det1,
	input  wire logic [15:0] det2,
	input  wire logic [15:0] det3,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_last,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             busy,
	output logic             irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [15:0]          rec_ff [arrb_pkg::REC_WORDS];
	arrb_pkg::arrb_state_e state_ff;
	logic [7:0]           cnt_ff;
	logic [7:0]           len_ff;
	logic [1:0]           irq_stat_ff;
	logic [1:0]           irq_mask_ff;
	logic                 done_ev;
	logic                 fail_ev;
	logic [6:0]           wr_word;

	function automatic logic [15:0] slave_detail(input logic [15:0] code, input logic [15:0] det);
		slave_detail = (code == arrb_pkg::ERR_SLAVE) ? det : arrb_pkg::NO_DETAIL;
	endfunction

	assign wr_word = 7'(arrb_pkg::OFS_DATA_FIRST + 7'(cnt_ff >> 1));
	assign done_ev = (state_ff == arrb_pkg::ARRB_BUILD) && rx_valid && rx_last;
	assign fail_ev = (state_ff == arrb_pkg::ARRB_IDLE) && start && !ok;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= arrb_pkg::ARRB_IDLE;
			cnt_ff   <= 8'h00;
			len_ff   <= 8'h00;
		end else begin
			case (state_ff)
				arrb_pkg::ARRB_IDLE: begin
					cnt_ff <= 8'h00;
					if (start && ok) begin
						len_ff   <= req_len;
						state_ff <= arrb_pkg::ARRB_BUILD;
					end
				end
				arrb_pkg::ARRB_BUILD: begin
					if (rx_valid) begin
						cnt_ff <= cnt_ff + 8'h01;
						if (rx_last)
							state_ff <= arrb_pkg::ARRB_IDLE;
					end
				end
				default: state_ff <= arrb_pkg::ARRB_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// record memory
	// ----------------------------------------
	// clearing the data and tail words at start keeps stale data out of unused lanes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < arrb_pkg::REC_WORDS; i++)
				rec_ff[i] <= arrb_pkg::ZERO_WORD;
		end else if (state_ff == arrb_pkg::ARRB_IDLE && start) begin
			for (int i = int'(arrb_pkg::OFS_DATA_FIRST); i < arrb_pkg::REC_WORDS; i++)
				rec_ff[i] <= arrb_pkg::ZERO_WORD;
			rec_ff[arrb_pkg::OFS_STATION] <= {1'b0,
				second_class_service ? communication_reference_number : 7'h00,
				1'b0, slave_station_address};
			if (ok) begin
				rec_ff[arrb_pkg::OFS_CODE] <= second_class_service ? arrb_pkg::RESP_CLASS2 : arrb_pkg::RESP_CLASS1;
				rec_ff[arrb_pkg::OFS_LEN_DET1]   <= {8'h00, req_len};
				rec_ff[arrb_pkg::OFS_SLOT_DET2]  <= {8'h00, req_slot};
				rec_ff[arrb_pkg::OFS_INDEX_DET3] <= {8'h00, req_index};
			end else begin
				rec_ff[arrb_pkg::OFS_CODE] <= err_code;
				rec_ff[arrb_pkg::OFS_LEN_DET1]   <= slave_detail(err_code, det1);
				rec_ff[arrb_pkg::OFS_SLOT_DET2]  <= slave_detail(err_code, det2);
				rec_ff[arrb_pkg::OFS_INDEX_DET3] <= slave_detail(err_code, det3);
			end
		end else if (state_ff == arrb_pkg::ARRB_BUILD && rx_valid && cnt_ff < len_ff
				&& cnt_ff < arrb_pkg::MAX_LEN) begin
			// drop excess bytes
			// oversized length must not spill into the tail words
			// byte at even cnt_ff low, at odd cnt_ff high
			if (cnt_ff[0])
				rec_ff[wr_word][15:8] <= rx_byte;
			else
				rec_ff[wr_word][7:0] <= rx_byte;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat_ff <= arrb_pkg::IRQ_RESET;
			irq_mask_ff <= arrb_pkg::MASK_RESET;
		end else begin
			// set wins over write-one-to-clear
			irq_stat_ff <= (irq_stat_ff & ~((reg_wr && reg_addr == arrb_pkg::REG_IRQ_STAT) ? reg_wdata[1:0] : 2'h0))
				| {fail_ev, done_ev};
			if (reg_wr && reg_addr == arrb_pkg::REG_IRQ_MASK)
				irq_mask_ff <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_ff & irq_mask_ff);
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			busy <= 1'b0;
		else
			busy <= (state_ff == arrb_pkg::ARRB_BUILD) && !done_ev || (state_ff == arrb_pkg::ARRB_IDLE && start && ok);
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			if (!reg_addr[7])
				reg_rdata <= rec_ff[reg_addr[6:0]];
			else if (reg_addr == arrb_pkg::REG_STATUS)
				reg_rdata <= {15'h0000, state_ff == arrb_pkg::ARRB_BUILD};
			else if (reg_addr == arrb_pkg::REG_IRQ_STAT)
				reg_rdata <= {14'h0000, irq_stat_ff};
			else if (reg_addr == arrb_pkg::REG_IRQ_MASK)
				reg_rdata <= {14'h0000, irq_mask_ff};
			else
				reg_rdata <= 16'h0000;
		end else
			reg_rdata <= 16'h0000;
	end
endmodule

//--- test/arrb_builder_sva.sv
// port checker for the response builder
`timescale 1ns/1ps
module arrb_builder_sva (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        start,
	input wire logic        second_class_service,
	input wire logic        ok,
	input wire logic [6:0]  slave_station_address,
	input wire logic [15:0] err_code,
	input wire logic        rx_valid,
	input wire logic        rx_last,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// header lands on the start edge, so a read one cycle later must see it
	wire logic go_c = start && !busy;
	wire logic rd0_c = reg_rd && reg_addr == 8'h00;
	wire logic rd1_c = reg_rd && reg_addr == 8'h01;
	wire logic rd2_c = reg_rd && reg_addr == 8'h02;
	property p_code; go_c && ok && second_class_service ##1 rd0_c |=> reg_rdata == 16'hA410; endproperty
	a_code: assert property (p_code) else $error("wrong success code");
	property p_stn; go_c ##1 rd1_c |=> reg_rdata[7:0] == {1'b0, $past(slave_station_address, 2)}; endproperty
	a_stn: assert property (p_stn) else $error("wrong station byte");
	property p_ref; go_c && !second_class_service ##1 rd1_c |=> reg_rdata[15:8] == 8'h00; endproperty
	a_ref: assert property (p_ref) else $error("reference byte not zero");
	property p_err; go_c && !ok ##1 rd0_c |=> reg_rdata == $past(err_code, 2); endproperty
	a_err: assert property (p_err) else $error("wrong error code");
	property p_det; go_c && !ok && err_code != 16'hE403 ##1 rd2_c |=> reg_rdata == 16'hFFFF; endproperty
	a_det: assert property (p_det) else $error("detail word not all ones");
	property p_busy; go_c && ok |=> busy; endproperty
	a_busy: assert property (p_busy) else $error("build did not start");
	property p_idle; go_c && !ok |=> !busy; endproperty
	a_idle: assert property (p_idle) else $error("failure started a build");
	property p_end; busy && rx_valid && rx_last |=> !busy; endproperty
	a_end: assert property (p_end) else $error("build did not end");
endmodule
bind arrb_builder arrb_builder_sva u_sva (.*);

//--- test/arrb_builder_tb.sv
// self-checking bench for the response builder
`timescale 1ns/1ps
module arrb_builder_tb;
	logic        clk, sys_rst, start, second_class_service, ok, rx_valid, rx_last, reg_wr, reg_rd, busy, irq, send;
	logic [6:0]  slave_station_address, communication_reference_number;
	logic [7:0]  req_len, req_slot, req_index, rx_byte, reg_addr, count;
	logic [15:0] err_code, det1, det2, det3, reg_wdata, reg_rdata;
	int          errors, tests_run;
	arrb_builder dut (.*);
	arrb_slave_model u_slave (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	// one bus cycle; it also drops start, so a request lasts one cycle
	task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		{start, send, reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'h0, w, !w, a, d};
		@(posedge clk);
		{reg_wr, reg_rd} <= 2'h0;
		if (!w) #1 chk("reg_rdata", d, reg_rdata);
	endtask
	task go(input logic o, c, input logic [7:0] l, input logic [15:0] e, input logic [7:0] a, input logic [15:0] x);
		@(posedge clk);
		{start, send, ok, second_class_service} <= {1'b1, o, o, c};
		{req_len, count, err_code} <= {l, l + 8'h02, e};
		{det1, det2, det3} <= {~e, e ^ 16'h00FF, e - 16'h0001};
		bus(1'b0, a, x);
		for (int i = 0; i < 300 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		chk("busy", 16'h0000, {15'h0000, busy});
	endtask
	task t_first;
		bus(1'b1, 8'h82, 16'h0003);
		go(1'b1, 1'b0, 8'h03, 16'h0000, 8'h01, 16'h007D);
		bus(1'b0, 8'h00, 16'hA400);
		bus(1'b0, 8'h03, 16'h00FE);
		bus(1'b0, 8'h04, 16'h00FF);
		bus(1'b0, 8'h05, 16'h4241);
		bus(1'b0, 8'h06, 16'h0043);
		bus(1'b0, 8'h07, 16'h0000);
		chk("irq", 16'h0001, {15'h0000, irq});
		bus(1'b1, 8'h81, 16'h0001);
		@(posedge clk);
		#1 chk("irq", 16'h0000, {15'h0000, irq});
		$display("first class read done");
	endtask
	task t_second;
		go(1'b1, 1'b1, 8'hF0, 16'h0000, 8'h00, 16'hA410);
		bus(1'b0, 8'h01, 16'h7E7D);
		bus(1'b0, 8'h02, 16'h00F0);
		bus(1'b0, 8'h7C, 16'h302F);
		$display("second class read done");
	endtask
	task t_fail;
		bus(1'b1, 8'h82, 16'h0000);
		go(1'b0, 1'b0, 8'h00, 16'hE403, 8'h00, 16'hE403);
		bus(1'b0, 8'h02, 16'h1BFC);
		bus(1'b0, 8'h03, 16'hE4FC);
		bus(1'b0, 8'h04, 16'hE402);
		bus(1'b0, 8'h05, 16'h0000);
		bus(1'b0, 8'h81, 16'h0003);
		chk("irq", 16'h0000, {15'h0000, irq});
		bus(1'b1, 8'h82, 16'h0002);
		repeat (2) @(posedge clk);
		#1 chk("irq", 16'h0001, {15'h0000, irq});
		$display("slave error done");
	endtask
	task t_other;
		go(1'b0, 1'b1, 8'h00, 16'hE501, 8'h02, 16'hFFFF);
		bus(1'b0, 8'h01, 16'h7E7D);
		bus(1'b0, 8'h04, 16'hFFFF);
		bus(1'b0, 8'h90, 16'h0000);
		bus(1'b0, 8'h80, 16'h0000);
		bus(1'b1, 8'h00, 16'h1234);
		bus(1'b0, 8'h00, 16'hE501);
		$display("other error done");
	endtask
	task end_of_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		sys_rst = 1'b1;
		{start, second_class_service, ok, reg_wr, reg_rd, send} = 6'h00;
		{req_len, count, reg_addr, reg_wdata, err_code, det1, det2, det3} = 104'h0;
		{slave_station_address, communication_reference_number, req_slot, req_index} = {7'h7D, 7'h7E, 8'hFE, 8'hFF};
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_first;
		t_second;
		t_fail;
		t_other;
		end_of_test;
	end
	initial begin
		repeat (4000) @(posedge clk);
		errors++;
		end_of_test;
	end
endmodule

//--- test/arrb_slave_model.sv
// slave model returning read bytes
`timescale 1ns/1ps
module arrb_slave_model (
	input  wire logic       clk,
	input  wire logic       send,
	input  wire logic [7:0] count,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_last
);
	logic [7:0] n_ff = 8'h00;
	logic [7:0] k_ff = 8'h00;
	wire logic  act = !send && k_ff != 8'h00 && k_ff <= n_ff;
	initial {rx_valid, rx_byte, rx_last} = 10'h000;
	// idle data toggles so a stale byte never reads as data
	always @(posedge clk) begin
		n_ff <= send ? count : n_ff;
		k_ff <= send ? 8'h01 : k_ff + {7'h00, act};
		rx_valid <= act;
		rx_last <= act && k_ff == n_ff;
		rx_byte <= act ? k_ff + 8'h40 : ~rx_byte;
	end
endmodule
